/* hw/ast_pkg.sv */
package ast_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_DATA  = 8'h00;
    localparam logic [7:0] OFF_FLAG  = 8'h04;
    localparam logic [7:0] OFF_IBRD  = 8'h08;
    localparam logic [7:0] OFF_FBRD  = 8'h0c;
    localparam logic [7:0] OFF_LCRH  = 8'h10;
    localparam logic [7:0] OFF_CTRL  = 8'h14;
    localparam logic [7:0] OFF_FLS   = 8'h18;
    localparam logic [7:0] OFF_ILPR  = 8'h1c;
    // flag register bit positions
    localparam int FLAG_BUSY   = 3;
    localparam int FLAG_RXFE   = 4;
    localparam int FLAG_TXFF   = 5;
    localparam int FLAG_RXFF   = 6;
    localparam int FLAG_TXFE   = 7;
    localparam int FLAG_RXLVL  = 8;
    localparam int FLAG_TXLVL  = 9;
    // reset values
    localparam logic [9:0] CTRL_RST  = 10'h300;
    localparam logic [7:0] LCRH_RST  = 8'h00;
    localparam logic [5:0] FLS_RST   = 6'h12;
    localparam logic [7:0] ILPR_RST  = 8'h00;
    // timing counts in oversample ticks
    localparam logic [3:0] OVS_LAST  = 4'hf;
    localparam logic [3:0] OVS_MID   = 4'h7;
    localparam logic [3:0] IR_PULSE  = 4'h3;
    localparam logic [22:0] FRAC_ONE = 23'h000040;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       sps;
        logic [1:0] wlen;
        logic       fifo_enable_bit;
        logic       stp2;
        logic       eps;
        logic       pen;
        logic       brk;
    } ast_lcr_t;

    typedef struct packed {
        logic       rx_enable_bit;
        logic       tx_enable_bit;
        logic [4:0] rsvd;
        logic       ir_low_power;
        logic       infrared_codec;
        logic       port_enable_bit;
    } ast_ctrl_t;

    typedef struct packed {
        logic       oe;
        logic       be;
        logic       pe;
        logic       fe;
        logic [7:0] data;
    } ast_rx_entry_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_DATA  = 3'b011,
        ST_PAR   = 3'b010,
        ST_STOP  = 3'b110
    } ast_state_t;
endpackage : ast_pkg

/* hw/ast_uart.sv */
// Overview of operation
// - 22-bit divisor: 16 integer, 6 fraction bits
// - tick at 16x baud, bits every 16
// - 30-bit shadow loads only on line-control write
// - frame: start, data lsb first, parity, stop
// - 5 to 8 data bits both directions
// - even, odd, stick or no parity
// - one or two stop bits
// - 16-deep fifos, rx entries carry status
// - enabled port sends frames until fifo empty
// - busy from non-empty until last stop
// - disable finishes current character first
// - tx and rx enables, both set after reset
// - start accepted only if low at eighth tick
// - data sampled every 16 ticks, parity checked
// - low stop bit flags framing error
// - char stored with overrun, parity, framing, break
// - break generated on output, detected on input
// - fill triggers 1/8 to 7/8, one-deep mode
// - infrared 3/16 pulses, low-power divider 1-256
// - fifos one deep until fifo enable set
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ast_uart
    import ast_pkg::*;
#(
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write channels
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read channels
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // serial line
    input  wire logic        serial_in,
    output logic             serial_out
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

    // software-visible state
    logic [15:0]   ibrd_q;
    logic [5:0]    fbrd_q;
    ast_lcr_t      lcr_q;
    ast_ctrl_t     pc_q;
    logic [5:0]    fls_q;
    logic [7:0]    ilpr_q;
    logic [29:0]   shadow_q;
    ast_lcr_t      lc;
    logic [21:0]   divisor;
    assign lc      = ast_lcr_t'(shadow_q[7:0]);
    assign divisor = shadow_q[29:8];

    // bus slave state
    logic          aw_held_q, w_held_q;
    logic [7:0]    aw_addr_q;
    logic [31:0]   w_data_q;
    logic [3:0]    w_strb_q;
    logic          do_wr, do_rd, lcrh_wr, tx_push, rx_pop;
    logic [7:0]    rd_addr;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[8*i +: 8] = n[8*i +: 8];
        end
        return r;
    endfunction : merge

    // write takes address and data in either order, one at a time
    assign awready = !aw_held_q && !bvalid;
    assign wready  = !w_held_q && !bvalid;
    assign do_wr   = aw_held_q && w_held_q && !bvalid;
    assign arready = !rvalid;
    assign do_rd   = arvalid && arready;
    assign rd_addr = araddr;
    assign lcrh_wr = do_wr && aw_addr_q == OFF_LCRH;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0;
            w_strb_q  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_held_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_wr) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= (aw_addr_q[1:0] == 2'h0 && aw_addr_q <= OFF_ILPR) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // addressed register widened to a bus word, so byte strobes merge into its old value
    logic [31:0] cur_word, new_word;
    always_comb begin
        case (aw_addr_q)
            OFF_IBRD: cur_word = {16'h0, ibrd_q};
            OFF_FBRD: cur_word = {26'h0, fbrd_q};
            OFF_LCRH: cur_word = {24'h0, lcr_q};
            OFF_CTRL: cur_word = {22'h0, pc_q};
            OFF_FLS:  cur_word = {26'h0, fls_q};
            OFF_ILPR: cur_word = {24'h0, ilpr_q};
            default:  cur_word = 32'h0;
        endcase
    end
    assign new_word = merge(cur_word, w_data_q, w_strb_q);

    // config registers; divisor halves only reach the baud logic with a line-control write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ibrd_q   <= 16'h0000;
            fbrd_q   <= 6'h00;
            lcr_q    <= ast_lcr_t'(LCRH_RST);
            pc_q     <= ast_ctrl_t'(CTRL_RST);
            fls_q    <= FLS_RST;
            ilpr_q   <= ILPR_RST;
            shadow_q <= {16'h0000, 6'h00, LCRH_RST};
        end else if (do_wr) begin
            case (aw_addr_q)
                OFF_IBRD: ibrd_q <= new_word[15:0];
                OFF_FBRD: fbrd_q <= new_word[5:0];
                OFF_LCRH: begin
                    lcr_q    <= ast_lcr_t'(new_word[7:0]);
                    shadow_q <= {ibrd_q, fbrd_q, new_word[7:0]};
                end
                OFF_CTRL: pc_q   <= ast_ctrl_t'(new_word[9:0]);
                OFF_FLS:  fls_q  <= new_word[5:0];
                OFF_ILPR: ilpr_q <= new_word[7:0];
                default: ;
            endcase
        end
    end

    // fractional baud generator: adds 64 per clock, ticks when the divisor is reached
    logic [22:0] acc_q, acc_sum;
    logic        tick;
    assign acc_sum = acc_q + FRAC_ONE;
    assign tick    = acc_sum >= {1'b0, divisor};
    always_ff @(posedge aclk) begin
        if (!aresetn || lcrh_wr) begin
            acc_q <= 23'h0;
        end else if (tick) begin
            acc_q <= acc_sum - {1'b0, divisor};
        end else begin
            acc_q <= acc_sum;
        end
    end

    // low-power infrared clock: system clock divided by ilpr+1, i.e. 1 to 256
    logic [7:0] lp_div_q;
    logic       lp_tick;
    assign lp_tick = lp_div_q == ilpr_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || lp_tick) begin
            lp_div_q <= 8'h00;
        end else begin
            lp_div_q <= lp_div_q + 8'h01;
        end
    end

    // fifo storage; without fifo enable the depth collapses to one
    logic [7:0]          tx_mem [DEPTH];
    ast_rx_entry_t       rx_mem [DEPTH];
    logic [PW-1:0]       tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
    logic [PW:0]         tx_cnt_q, rx_cnt_q, cap;
    logic                tx_full, tx_empty, rx_full, rx_empty, tx_pop, rx_push;
    ast_rx_entry_t       rx_entry;
    assign cap      = lc.fifo_enable_bit ? DEPTH_C : (PW+1)'(1);
    assign tx_full  = tx_cnt_q >= cap;
    assign rx_full  = rx_cnt_q >= cap;
    assign tx_empty = tx_cnt_q == '0;
    assign rx_empty = rx_cnt_q == '0;
    assign tx_push  = do_wr && aw_addr_q == OFF_DATA && w_strb_q[0] && !tx_full;
    assign rx_pop   = do_rd && rd_addr == OFF_DATA && !rx_empty;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_wp_q  <= '0;
            tx_rp_q  <= '0;
            tx_cnt_q <= '0;
        end else begin
            if (tx_push) begin
                tx_mem[tx_wp_q] <= w_data_q[7:0];
                tx_wp_q         <= tx_wp_q + PW'(1);
            end
            if (tx_pop) tx_rp_q <= tx_rp_q + PW'(1);
            tx_cnt_q <= tx_cnt_q + (PW+1)'(tx_push) - (PW+1)'(tx_pop);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_wp_q  <= '0;
            rx_rp_q  <= '0;
            rx_cnt_q <= '0;
        end else begin
            if (rx_push) begin
                rx_mem[rx_wp_q] <= rx_entry;
                rx_wp_q         <= rx_wp_q + PW'(1);
            end
            if (rx_pop) rx_rp_q <= rx_rp_q + PW'(1);
            rx_cnt_q <= rx_cnt_q + (PW+1)'(rx_push) - (PW+1)'(rx_pop);
        end
    end

    // fill-level trigger: 1/8, 1/4, 1/2, 3/4, 7/8 of the active depth
    function automatic logic [PW:0] level(input logic [2:0] sel, input logic [PW:0] c);
        case (sel)
            3'h0:    return c >> 3;
            3'h1:    return c >> 2;
            3'h2:    return c >> 1;
            3'h3:    return c - (c >> 2);
            default: return c - (c >> 3);
        endcase
    endfunction : level
    logic rx_lvl, tx_lvl;
    assign rx_lvl = rx_cnt_q >= level(fls_q[5:3], cap) && !rx_empty;
    assign tx_lvl = tx_cnt_q <= level(fls_q[2:0], cap);

    // parity of the active data bits; stick forces the opposite of the even select
    function automatic logic par_of(input logic [7:0] d, input ast_lcr_t l);
        logic [7:0] m;
        m = d & (8'hff >> (2'h3 - l.wlen));
        if (l.sps) return !l.eps;
        return l.eps ? ^m : ~^m;
    endfunction : par_of

    // transmitter: enable is only looked at between characters
    ast_state_t tx_st_q;
    logic [3:0] tcnt_q;
    logic [2:0] tbit_q;
    logic [7:0] tsh_q;
    logic       tpar_q, tx_bit_end, tx_line;
    logic [1:0] lp_cnt_q;
    assign tx_pop     = tx_st_q == ST_IDLE && pc_q.port_enable_bit && pc_q.tx_enable_bit && !tx_empty;
    assign tx_bit_end = tick && tcnt_q == OVS_LAST;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_st_q <= ST_IDLE;
            tcnt_q  <= 4'h0;
            tbit_q  <= 3'h0;
            tsh_q   <= 8'h00;
            tpar_q  <= 1'b0;
        end else begin
            if (tx_st_q != ST_IDLE && tick) tcnt_q <= tcnt_q + 4'h1;
            case (tx_st_q)
                ST_IDLE: if (tx_pop) begin
                    tx_st_q <= ST_START;
                    tsh_q   <= tx_mem[tx_rp_q];
                    tpar_q  <= par_of(tx_mem[tx_rp_q], lc);
                    tcnt_q  <= 4'h0;
                    tbit_q  <= 3'h0;
                end
                ST_START: if (tx_bit_end) tx_st_q <= ST_DATA;
                ST_DATA: if (tx_bit_end) begin
                    tsh_q <= tsh_q >> 1;
                    if (tbit_q == {1'b1, lc.wlen}) begin
                        tx_st_q <= lc.pen ? ST_PAR : ST_STOP;
                        tbit_q  <= 3'h0;
                    end else begin
                        tbit_q <= tbit_q + 3'h1;
                    end
                end
                ST_PAR: if (tx_bit_end) tx_st_q <= ST_STOP;
                ST_STOP: if (tx_bit_end) begin
                    if (lc.stp2 && tbit_q == 3'h0) tbit_q <= 3'h1;
                    else tx_st_q <= ST_IDLE;
                end
                default: tx_st_q <= ST_IDLE;
            endcase
        end
    end

    always_comb begin
        case (tx_st_q)
            ST_START: tx_line = 1'b0;
            ST_DATA:  tx_line = tsh_q[0];
            ST_PAR:   tx_line = tpar_q;
            default:  tx_line = 1'b1;
        endcase
    end

    // low-power pulse counts three divided clocks from each bit start
    always_ff @(posedge aclk) begin
        if (!aresetn || tx_bit_end || tx_pop) begin
            lp_cnt_q <= 2'h0;
        end else if (lp_tick && lp_cnt_q != 2'h3) begin
            lp_cnt_q <= lp_cnt_q + 2'h1;
        end
    end

    // output: break wins, infrared sends a short high pulse for each zero
    logic busy;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_out <= 1'b1;
        end else if (lc.brk) begin
            serial_out <= 1'b0;
        end else if (pc_q.infrared_codec) begin
            serial_out <= !tx_line && (pc_q.ir_low_power ? lp_cnt_q != 2'h3 : tcnt_q < IR_PULSE);
        end else begin
            serial_out <= tx_line;
        end
    end
    assign busy = !tx_empty || tx_st_q != ST_IDLE;

    // infrared decode stretches each low pulse to roughly one bit
    logic [3:0] ir_hold_q;
    logic       rx_line;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ir_hold_q <= 4'h0;
        end else if (!serial_in) begin
            ir_hold_q <= OVS_LAST;
        end else if (tick && ir_hold_q != 4'h0) begin
            ir_hold_q <= ir_hold_q - 4'h1;
        end
    end
    assign rx_line = pc_q.infrared_codec ? (serial_in && ir_hold_q == 4'h0) : serial_in;

    // last line level; idle high after reset, and a low stop bit must go high before a new start
    logic rx_prev_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) rx_prev_q <= 1'b1;
        else rx_prev_q <= rx_line;
    end

    // receiver: start checked at mid-bit, then one sample every 16 ticks
    ast_state_t rx_st_q;
    logic [3:0] rcnt_q;
    logic [2:0] rbit_q;
    logic [7:0] rsh_q;
    logic       rpe_q, rpar_q, oe_q, rx_samp, rx_done;
    assign rx_samp = tick && rcnt_q == OVS_LAST;
    assign rx_done = rx_st_q == ST_STOP && rx_samp;
    assign rx_push = rx_done && !rx_full;
    assign rx_entry = '{oe: oe_q, be: rsh_q == 8'h00 && !rpar_q && !rx_line,
                        pe: rpe_q, fe: !rx_line, data: rsh_q};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_st_q <= ST_IDLE;
            rcnt_q  <= 4'h0;
            rbit_q  <= 3'h0;
            rsh_q   <= 8'h00;
            rpe_q   <= 1'b0;
            rpar_q  <= 1'b0;
        end else begin
            if (rx_st_q != ST_IDLE && tick) rcnt_q <= rcnt_q + 4'h1;
            case (rx_st_q)
                ST_IDLE: if (pc_q.port_enable_bit && pc_q.rx_enable_bit && rx_prev_q && !rx_line) begin
                    rx_st_q <= ST_START;
                    rcnt_q  <= 4'h0;
                    rbit_q  <= 3'h0;
                    rsh_q   <= 8'h00;
                    rpe_q   <= 1'b0;
                    rpar_q  <= 1'b0;
                end
                ST_START: if (tick && rcnt_q == OVS_MID) begin
                    rcnt_q  <= 4'h0;
                    rx_st_q <= rx_line ? ST_IDLE : ST_DATA;
                end
                ST_DATA: if (rx_samp) begin
                    rsh_q[rbit_q] <= rx_line;
                    if (rbit_q == {1'b1, lc.wlen}) rx_st_q <= lc.pen ? ST_PAR : ST_STOP;
                    else rbit_q <= rbit_q + 3'h1;
                end
                ST_PAR: if (rx_samp) begin
                    rpar_q  <= rx_line;
                    rpe_q   <= rx_line != par_of(rsh_q, lc);
                    rx_st_q <= ST_STOP;
                end
                ST_STOP: if (rx_samp) rx_st_q <= ST_IDLE;
                default: rx_st_q <= ST_IDLE;
            endcase
        end
    end

    // overrun stays pending until it rides on the next stored character
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oe_q <= 1'b0;
        end else if (rx_done && rx_full) begin
            oe_q <= 1'b1;
        end else if (rx_push) begin
            oe_q <= 1'b0;
        end
    end

    // read channel; reading the data word pops the receive fifo
    logic [31:0] rd_val;
    logic        rd_ok;
    always_comb begin
        rd_val = 32'h0;
        rd_ok  = 1'b1;
        case (rd_addr)
            OFF_DATA: rd_val = rx_empty ? 32'h0 : {20'h0, rx_mem[rx_rp_q]};
            OFF_FLAG: begin
                rd_val[FLAG_BUSY]  = busy;
                rd_val[FLAG_RXFE]  = rx_empty;
                rd_val[FLAG_TXFF]  = tx_full;
                rd_val[FLAG_RXFF]  = rx_full;
                rd_val[FLAG_TXFE]  = tx_empty;
                rd_val[FLAG_RXLVL] = rx_lvl;
                rd_val[FLAG_TXLVL] = tx_lvl;
            end
            OFF_IBRD: rd_val = {16'h0, ibrd_q};
            OFF_FBRD: rd_val = {26'h0, fbrd_q};
            OFF_LCRH: rd_val = {24'h0, lcr_q};
            OFF_CTRL: rd_val = {22'h0, pc_q};
            OFF_FLS:  rd_val = {26'h0, fls_q};
            OFF_ILPR: rd_val = {24'h0, ilpr_q};
            default:  rd_ok  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= RESP_OKAY;
        end else if (do_rd) begin
            rvalid <= 1'b1;
            rdata  <= rd_val;
            rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // checks
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence tx_launch_s;
        tx_pop ##1 tx_st_q == ST_START;
    endsequence
    sequence rx_glitch_s;
        rx_st_q == ST_START && tick && rcnt_q == OVS_MID && rx_line;
    endsequence

    shadow_hold_a: assert property (!lcrh_wr |=> $stable(shadow_q))
        else $error("divisor shadow changed without line-control write");
    frame_launch_a: assert property (tx_pop |-> ##1 tx_st_q == ST_START ##1 tx_st_q == ST_START)
        else $error("frame did not start after fifo pop");
    busy_launch_a: assert property (tx_launch_s |-> busy)
        else $error("busy low during frame");
    busy_push_a: assert property (tx_push |=> busy)
        else $error("busy not raised by fifo write");
    start_low_a: assert property ($past(tx_st_q == ST_START && !lc.brk && !pc_q.infrared_codec) |-> !serial_out)
        else $error("start bit not low");
    glitch_drop_a: assert property (rx_glitch_s |=> rx_st_q == ST_IDLE && !rx_push)
        else $error("false start accepted");
    overrun_keep_a: assert property (rx_done && rx_full && !rx_pop |=> oe_q && $stable(rx_cnt_q))
        else $error("overrun not flagged or fifo changed");
    one_deep_a: assert property (!lc.fifo_enable_bit |-> tx_cnt_q <= 1 && rx_cnt_q <= 1)
        else $error("fifo deeper than one while disabled");
    enables_reset_a: assert property ($past(!aresetn) |->
                                      pc_q.tx_enable_bit && pc_q.rx_enable_bit && !lc.fifo_enable_bit)
        else $error("enables not set after reset");
    break_out_a: assert property ($past(lc.brk) |-> !serial_out)
        else $error("break not driven low");
endmodule : ast_uart
`default_nettype wire

/* testbench/ast_remote.sv */
`timescale 1ns/1ps
`default_nettype none
// remote serial port: even parity, 8 data bits, one stop bit
module ast_remote #(
    parameter int BIT = 32
) (
    // clock
    input  wire logic        aclk,
    // serial lines
    input  wire logic        tx_line,
    output logic             rx_line,
    // captured frame
    output logic [7:0]       got_q,
    output logic             got_par_q,
    output logic             got_stop_q,
    output int               n_got
);
    initial rx_line = 1'b1;
    initial n_got = 0;
    // sample mid-bit so edge jitter of the sender cannot hurt
    always begin
        @(negedge tx_line);
        repeat (BIT / 2) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge aclk);
            got_q[i] = tx_line;
        end
        repeat (BIT) @(posedge aclk);
        got_par_q = tx_line;
        repeat (BIT) @(posedge aclk);
        got_stop_q = tx_line;
        n_got++;
    end
    // whole frame, line back to idle high afterwards
    task automatic send(input logic [7:0] d, input logic stop_ok);
        logic [10:0] f;
        begin
            f = {stop_ok, ^d, d, 1'b0};
            for (int i = 0; i < 11; i++) begin
                @(posedge aclk);
                rx_line <= f[i];
                repeat (BIT - 1) @(posedge aclk);
            end
            @(posedge aclk);
            rx_line <= 1'b1;
        end
    endtask : send
    // low pulse shorter than half a bit
    task automatic glitch();
        begin
            @(posedge aclk);
            rx_line <= 1'b0;
            repeat (4) @(posedge aclk);
            rx_line <= 1'b1;
            repeat (BIT) @(posedge aclk);
        end
    endtask : glitch
endmodule : ast_remote
`default_nettype wire

/* testbench/ast_uart_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module ast_uart_bench;
    import ast_pkg::*;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] m;
        logic [1:0]  r;
    } ast_row_t;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, serial_in, serial_out, got_par, got_stop;
    logic [1:0]  bresp, rresp, resp;
    logic [7:0]  got;
    logic [31:0] rdata, rd;
    int          fail_count = 0, n_compared = 0, n_got;
    ast_row_t    rows [7];

    always #20 aclk = ~aclk;

    ast_uart u_ast_uart (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .serial_in(serial_in), .serial_out(serial_out));
    ast_remote #(.BIT(32)) u_ast_remote (.aclk(aclk), .tx_line(serial_out), .rx_line(serial_in),
        .got_q(got), .got_par_q(got_par), .got_stop_q(got_stop), .n_got(n_got));

    task automatic conclude();
        begin
            if (fail_count == 0 && n_compared > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask : conclude

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        begin
            n_compared++;
            if (g !== e) begin
                fail_count++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask : chk

    // handshakes are read at the rising edge that takes them, before that edge's updates land
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic tb;
        begin
            @(posedge aclk);
            awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
            tb = 1'b0;
            while (!tb) begin
                @(posedge aclk);
                tb = bvalid & bready; resp = bresp;
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (tb) bready <= 1'b0;
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        logic tr;
        begin
            @(posedge aclk);
            araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
            tr = 1'b0;
            while (!tr) begin
                @(posedge aclk);
                tr = rvalid & rready; rd = rdata; resp = rresp;
                if (arready) arvalid <= 1'b0;
                if (tr) rready <= 1'b0;
            end
        end
    endtask : axi_rd

    // run takes about 3500 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        conclude();
    end

    initial begin
        rows = '{'{OFF_FLAG, 32'h90, 32'hf8, RESP_OKAY}, '{OFF_CTRL, 32'h300, 32'h3ff, RESP_OKAY},
                 '{OFF_LCRH, 32'h0, 32'hff, RESP_OKAY}, '{OFF_FLS, 32'h12, 32'h3f, RESP_OKAY},
                 '{OFF_IBRD, 32'h0, 32'hffff, RESP_OKAY}, '{8'h20, 32'h0, 32'h0, RESP_SLVERR},
                 '{8'h02, 32'h0, 32'h0, RESP_SLVERR}};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            axi_rd(rows[i].a);
            chk(rd & rows[i].m, rows[i].d);
            chk(resp, rows[i].r);
        end
        axi_wr(8'h24, 32'h1);
        chk(resp, RESP_SLVERR);
        // divisor 2.0 gives a 32-clock bit; port still disabled here
        axi_wr(OFF_IBRD, 32'h2);
        axi_wr(OFF_FBRD, 32'h0);
        axi_wr(OFF_LCRH, 32'h76);
        axi_wr(OFF_CTRL, 32'h301);
        axi_wr(OFF_DATA, 32'ha5);
        axi_wr(OFF_DATA, 32'h5a);
        axi_wr(OFF_DATA, 32'h3c);
        axi_rd(OFF_FLAG);
        chk(rd[FLAG_BUSY], 1'b1);
        wait (n_got == 1);
        chk({got_stop, got_par, got}, {1'b1, ^8'ha5, 8'ha5});
        wait (n_got == 2);
        chk({got_stop, got_par, got}, {1'b1, ^8'h5a, 8'h5a});
        repeat (96) @(posedge aclk);
        axi_wr(OFF_CTRL, 32'h300);
        wait (n_got == 3);
        chk({got_stop, got_par, got}, {1'b1, ^8'h3c, 8'h3c});
        repeat (64) @(posedge aclk);
        axi_rd(OFF_FLAG);
        chk(rd[7:3], 5'b10010);
        // receive path: a short glitch, a good char, a bad stop
        axi_wr(OFF_CTRL, 32'h301);
        u_ast_remote.glitch();
        u_ast_remote.send(8'h96, 1'b1);
        u_ast_remote.send(8'h21, 1'b0);
        repeat (40) @(posedge aclk);
        axi_rd(OFF_DATA);
        chk(rd[11:0], 12'h096);
        axi_rd(OFF_DATA);
        chk(rd[11:0], 12'h121);
        axi_rd(OFF_FLAG);
        chk(rd[FLAG_RXFE], 1'b1);
        // one-deep mode: a break, then a char that overruns the full holding register
        axi_wr(OFF_CTRL, 32'h300);
        axi_wr(OFF_LCRH, 32'h66);
        axi_wr(OFF_CTRL, 32'h301);
        u_ast_remote.send(8'h00, 1'b0);
        u_ast_remote.send(8'h33, 1'b1);
        repeat (40) @(posedge aclk);
        axi_rd(OFF_DATA);
        chk(rd[11:0], 12'h500);
        axi_rd(OFF_FLAG);
        chk(rd[FLAG_RXFE], 1'b1);
        u_ast_remote.send(8'h33, 1'b1);
        repeat (40) @(posedge aclk);
        axi_rd(OFF_DATA);
        chk(rd[11:0], 12'h833);
        // a break on the output reaches the remote as an all-zero frame
        axi_wr(OFF_CTRL, 32'h300);
        axi_wr(OFF_LCRH, 32'h67);
        wait (n_got == 4);
        chk({got_stop, got_par, got}, 10'h0);
        axi_wr(OFF_LCRH, 32'h66);
        conclude();
    end
endmodule : ast_uart_bench
`default_nettype wire
